// ### design/lpt_consts.svh
// Constants of the LCD timing port: register map, fields, reset values, response codes
`ifndef LPT_CONSTS_SVH
`define LPT_CONSTS_SVH

`define LPT_AW            8
`define LPT_HW            10

`define LPT_OFF_CTRL      8'h00
`define LPT_OFF_HSIZE     8'h04
`define LPT_OFF_VSIZE     8'h08
`define LPT_OFF_ACCNT     8'h0C
`define LPT_OFF_CPHALF    8'h10
`define LPT_OFF_HGAP      8'h14
`define LPT_OFF_STATUS    8'h18

`define LPT_CTRL_EN       0
`define LPT_CTRL_MODE     1
`define LPT_CTRL_SPLIT    3
`define LPT_CTRL_ACLINE   4

`define LPT_STAT_IDLE     0
`define LPT_STAT_POL      1
`define LPT_STAT_UNDER    2
`define LPT_STAT_LINE     16

`define LPT_RST_HSIZE     10'h050
`define LPT_RST_VSIZE     10'h0F0
`define LPT_RST_ACCNT     8'h0D
`define LPT_RST_CPHALF    8'h04
`define LPT_RST_HGAP      10'h002

`define LPT_RESP_OKAY     2'h0
`define LPT_RESP_SLVERR   2'h2

`endif

// ### design/lpt_pkg.sv
// Shared types of the LCD timing port
`include "lpt_consts.svh"
package lpt_pkg;

  typedef enum logic [1:0] {
    LPT_MONO  = 2'h0,
    LPT_GRAY  = 2'h1,
    LPT_COLOR = 2'h2
  } lpt_mode_t;

  typedef enum logic [2:0] {ST_OFF, ST_SHIFT, ST_LATCH, ST_GAP, ST_FRAME} lpt_state_t;

  typedef struct packed {
    lpt_state_t         state;
    logic [7:0]         div;
    logic               cp;
    logic [`LPT_HW:0]   nib;
    logic [`LPT_HW-1:0] line;
    logic [`LPT_HW-1:0] gap;
    logic [3:0]         phase;
    logic [3:0]         nibble;
    logic               load;
    logic               frame;
    logic               load_ev;
    logic               frame_ev;
    logic               idle;
    logic               ready;
    logic               under;
    logic               pol;
    logic               en;
    lpt_mode_t          mode;
    logic               split;
    logic               ac_line;
    logic [`LPT_HW-1:0] hsize;
    logic [`LPT_HW-1:0] vsize;
    logic [7:0]         accnt;
    logic [7:0]         cphalf;
    logic [`LPT_HW-1:0] hgap;
    logic               awready;
    logic [`LPT_AW-1:0] awaddr;
    logic               wready;
    logic [31:0]        wdata;
    logic [3:0]         wstrb;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               arready;
    logic               rvalid;
    logic [31:0]        rdata;
    logic [1:0]         rresp;
  } lpt_top_st_t;

  typedef struct packed {
    logic       pol;
    logic [7:0] cnt;
  } lpt_ac_st_t;

endpackage

// ### design/lpt_core_if.sv
// Signals between the sequencer, the dither stage and the polarity generator
`timescale 1ns/10ps
`default_nettype none
interface lpt_core_if;
  logic [15:0]        pix_word;
  lpt_pkg::lpt_mode_t mode;
  logic [3:0]         phase;
  logic [3:0]         nibble;
  logic               run;
  logic               ac_line;
  logic [7:0]         ac_count;
  logic               load_ev;
  logic               frame_ev;
  logic               polarity;

  modport seq  (output pix_word, mode, phase, run, ac_line, ac_count, load_ev, frame_ev,
                input nibble, polarity);
  modport dith (input pix_word, mode, phase, output nibble);
  modport acp  (input run, ac_line, ac_count, load_ev, frame_ev, output polarity);
endinterface
`default_nettype wire

// ### design/lpt_dither.sv
// Pixel mode stage: four pixel levels in, one panel nibble out
`timescale 1ns/10ps
`default_nettype none
module lpt_dither (
  lpt_core_if.dith cif
);
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_pix
      logic [3:0] lvl;
      logic [3:0] thr;
      assign lvl = cif.pix_word[4*i +: 4];
      // Colour subpixels get staggered thresholds so the flicker spreads across them
      assign thr = (cif.mode == lpt_pkg::LPT_COLOR) ? 4'(cif.phase + 4'(4 * i)) : cif.phase;
      always_comb begin
        case (cif.mode)
          lpt_pkg::LPT_GRAY,
          lpt_pkg::LPT_COLOR: cif.nibble[i] = (lvl > thr);
          default:            cif.nibble[i] = lvl[3];
        endcase
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ### design/lpt_ac_pol.sv
// AC drive polarity generator, per frame or per programmable count of line latches
`timescale 1ns/10ps
`default_nettype none
module lpt_ac_pol (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ce,
  lpt_core_if.acp   cif
);
  lpt_pkg::lpt_ac_st_t st_ff;
  lpt_pkg::lpt_ac_st_t nxt_st;

  assign cif.polarity = st_ff.pol;

  always_comb begin
    nxt_st = st_ff;
    if (!cif.run) begin
      nxt_st.pol = 1'b0;
      nxt_st.cnt = 8'h00;
    end else if (cif.ac_line) begin
      if (cif.load_ev) begin
        if (st_ff.cnt >= cif.ac_count - 8'h01) begin
          nxt_st.pol = !st_ff.pol;
          nxt_st.cnt = 8'h00;
        end else begin
          nxt_st.cnt = st_ff.cnt + 8'h01;
        end
      end
    end else if (cif.frame_ev) begin
      nxt_st.pol = !st_ff.pol;
      nxt_st.cnt = 8'h00;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '{pol: 1'b0, cnt: 8'h00};
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end
endmodule
`default_nettype wire

// ### design/lpt_top.sv
// LCD timing port: register slave, line and frame sequencer, panel pin drivers
`timescale 1ns/10ps
`default_nettype none
`include "lpt_consts.svh"
module lpt_top (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic               ce,
  input  wire logic [`LPT_AW-1:0] s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [`LPT_AW-1:0] s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  input  wire logic [15:0]        pix_word,
  input  wire logic               pix_valid,
  output logic                    pix_ready,
  output logic                    pixel_shift_clock,
  output logic [3:0]              pixel_nibble,
  output logic                    line_latch,
  output logic                    frame_start,
  output logic                    ac_polarity_toggle,
  output logic                    panel_enable,
  output logic                    video_idle_flag
);
  localparam lpt_pkg::lpt_top_st_t RST_ST = '{
    state:   lpt_pkg::ST_OFF,
    mode:    lpt_pkg::LPT_MONO,
    hsize:   `LPT_RST_HSIZE,
    vsize:   `LPT_RST_VSIZE,
    accnt:   `LPT_RST_ACCNT,
    cphalf:  `LPT_RST_CPHALF,
    hgap:    `LPT_RST_HGAP,
    idle:    1'b1,
    awready: 1'b1,
    wready:  1'b1,
    arready: 1'b1,
    default: '0
  };

  lpt_pkg::lpt_top_st_t st_ff;
  lpt_pkg::lpt_top_st_t nxt_st;
  lpt_core_if           cif ();

  logic [`LPT_HW:0] line_len;
  logic             tick;
  logic [31:0]      wmask;
  logic [31:0]      wval;

  function automatic logic is_mapped(input logic [`LPT_AW-1:0] a);
    case (a)
      `LPT_OFF_CTRL, `LPT_OFF_HSIZE, `LPT_OFF_VSIZE, `LPT_OFF_ACCNT,
      `LPT_OFF_CPHALF, `LPT_OFF_HGAP, `LPT_OFF_STATUS: is_mapped = 1'b1;
      default:                                          is_mapped = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] rd_val(input lpt_pkg::lpt_top_st_t s,
                                         input logic [`LPT_AW-1:0]   a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      `LPT_OFF_CTRL: begin
        v[`LPT_CTRL_EN]       = s.en;
        v[`LPT_CTRL_MODE +: 2] = s.mode;
        v[`LPT_CTRL_SPLIT]    = s.split;
        v[`LPT_CTRL_ACLINE]   = s.ac_line;
      end
      `LPT_OFF_HSIZE:  v[`LPT_HW-1:0] = s.hsize;
      `LPT_OFF_VSIZE:  v[`LPT_HW-1:0] = s.vsize;
      `LPT_OFF_ACCNT:  v[7:0]         = s.accnt;
      `LPT_OFF_CPHALF: v[7:0]         = s.cphalf;
      `LPT_OFF_HGAP:   v[`LPT_HW-1:0] = s.hgap;
      `LPT_OFF_STATUS: begin
        v[`LPT_STAT_IDLE]               = s.idle;
        v[`LPT_STAT_POL]                = s.pol;
        v[`LPT_STAT_UNDER]              = s.under;
        v[`LPT_STAT_LINE +: `LPT_HW]    = s.line;
      end
      default: v = 32'h0000_0000;
    endcase
    rd_val = v;
  endfunction

  assign cif.pix_word = pix_word;
  assign cif.mode     = st_ff.mode;
  assign cif.phase    = st_ff.phase;
  assign cif.run      = st_ff.en;
  assign cif.ac_line  = st_ff.ac_line;
  assign cif.ac_count = st_ff.accnt;
  // Events come from the next state so a polarity flip lands in the idle gap, not a burst
  assign cif.load_ev  = nxt_st.load_ev;
  assign cif.frame_ev = nxt_st.frame_ev;

  lpt_dither u_dither (
    .cif (cif.dith)
  );

  lpt_ac_pol u_ac_pol (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .cif     (cif.acp)
  );

  // Split panels interleave upper and lower half nibbles on one line
  assign line_len = st_ff.split ? {st_ff.hsize, 1'b0} : {1'b0, st_ff.hsize};
  assign tick     = (st_ff.div == st_ff.cphalf - 8'h01);
  assign wmask    = {{8{st_ff.wstrb[3]}}, {8{st_ff.wstrb[2]}},
                     {8{st_ff.wstrb[1]}}, {8{st_ff.wstrb[0]}}};
  assign wval     = (rd_val(st_ff, st_ff.awaddr) & ~wmask) | (st_ff.wdata & wmask);

  always_comb begin
    nxt_st          = st_ff;
    nxt_st.load_ev  = 1'b0;
    nxt_st.frame_ev = 1'b0;
    nxt_st.pol      = cif.polarity;

    // Register slave: address and data are taken in either order
    if (st_ff.awready && s_axi_awvalid) begin
      nxt_st.awaddr  = s_axi_awaddr;
      nxt_st.awready = 1'b0;
    end
    if (st_ff.wready && s_axi_wvalid) begin
      nxt_st.wdata  = s_axi_wdata;
      nxt_st.wstrb  = s_axi_wstrb;
      nxt_st.wready = 1'b0;
    end
    if (!st_ff.awready && !st_ff.wready && !st_ff.bvalid) begin
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp  = is_mapped(st_ff.awaddr) ? `LPT_RESP_OKAY : `LPT_RESP_SLVERR;
      case (st_ff.awaddr)
        `LPT_OFF_CTRL: begin
          nxt_st.en      = wval[`LPT_CTRL_EN];
          nxt_st.mode    = lpt_pkg::lpt_mode_t'(wval[`LPT_CTRL_MODE +: 2]);
          nxt_st.split   = wval[`LPT_CTRL_SPLIT];
          nxt_st.ac_line = wval[`LPT_CTRL_ACLINE];
        end
        // Zero sizes would wrap the terminal counts, so they are raised to one
        `LPT_OFF_HSIZE:  nxt_st.hsize  = (wval[`LPT_HW-1:0] == '0) ? 10'h001 : wval[`LPT_HW-1:0];
        `LPT_OFF_VSIZE:  nxt_st.vsize  = (wval[`LPT_HW-1:0] == '0) ? 10'h001 : wval[`LPT_HW-1:0];
        `LPT_OFF_ACCNT:  nxt_st.accnt  = (wval[7:0] == 8'h00) ? 8'h01 : wval[7:0];
        `LPT_OFF_CPHALF: nxt_st.cphalf = (wval[7:0] == 8'h00) ? 8'h01 : wval[7:0];
        `LPT_OFF_HGAP:   nxt_st.hgap   = wval[`LPT_HW-1:0];
        `LPT_OFF_STATUS: begin
          if (st_ff.wstrb[0] && st_ff.wdata[`LPT_STAT_UNDER]) begin
            nxt_st.under = 1'b0;
          end
        end
        default: nxt_st.bresp = `LPT_RESP_SLVERR;
      endcase
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid  = 1'b0;
      nxt_st.awready = 1'b1;
      nxt_st.wready  = 1'b1;
    end
    if (st_ff.arready && s_axi_arvalid) begin
      nxt_st.rdata   = rd_val(st_ff, s_axi_araddr);
      nxt_st.rresp   = is_mapped(s_axi_araddr) ? `LPT_RESP_OKAY : `LPT_RESP_SLVERR;
      nxt_st.rvalid  = 1'b1;
      nxt_st.arready = 1'b0;
    end
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid  = 1'b0;
      nxt_st.arready = 1'b1;
    end

    // Sequencer; a half period of the pixel clock is cphalf system clocks
    if (!st_ff.en) begin
      nxt_st.state  = lpt_pkg::ST_OFF;
      nxt_st.div    = 8'h00;
      nxt_st.cp     = 1'b0;
      nxt_st.nibble = 4'h0;
      nxt_st.load   = 1'b0;
      nxt_st.frame  = 1'b0;
      nxt_st.nib    = '0;
      nxt_st.line   = '0;
      nxt_st.gap    = '0;
    end else begin
      nxt_st.div = tick ? 8'h00 : st_ff.div + 8'h01;
      case (st_ff.state)
        lpt_pkg::ST_OFF: begin
          nxt_st.state = lpt_pkg::ST_SHIFT;
          nxt_st.div   = 8'h00;
        end
        lpt_pkg::ST_SHIFT: begin
          if (tick) begin
            if (!st_ff.cp) begin
              nxt_st.cp = 1'b1;
              if (pix_valid && st_ff.ready) begin
                nxt_st.nibble = cif.nibble;
              end else begin
                nxt_st.nibble = 4'h0;
                nxt_st.under  = 1'b1;
              end
            end else begin
              nxt_st.cp = 1'b0;
              if (st_ff.nib == line_len - 11'h001) begin
                nxt_st.nib     = '0;
                nxt_st.state   = lpt_pkg::ST_LATCH;
                nxt_st.load    = 1'b1;
                nxt_st.load_ev = 1'b1;
              end else begin
                nxt_st.nib = st_ff.nib + 11'h001;
              end
            end
          end
        end
        lpt_pkg::ST_LATCH: begin
          if (tick) begin
            // Last nibble stays put: data may only move with a rising pixel clock
            nxt_st.load   = 1'b0;
            nxt_st.gap    = '0;
            if (st_ff.line == st_ff.vsize - 10'h001) begin
              nxt_st.line     = '0;
              nxt_st.state    = lpt_pkg::ST_FRAME;
              nxt_st.frame    = 1'b1;
              nxt_st.frame_ev = 1'b1;
            end else begin
              nxt_st.line  = st_ff.line + 10'h001;
              nxt_st.state = lpt_pkg::ST_GAP;
            end
          end
        end
        lpt_pkg::ST_FRAME: begin
          if (tick) begin
            nxt_st.frame = 1'b0;
            nxt_st.phase = st_ff.phase + 4'h1;
            nxt_st.state = lpt_pkg::ST_GAP;
          end
        end
        lpt_pkg::ST_GAP: begin
          if (tick) begin
            if (st_ff.gap >= st_ff.hgap) begin
              nxt_st.state = lpt_pkg::ST_SHIFT;
            end else begin
              nxt_st.gap = st_ff.gap + 10'h001;
            end
          end
        end
        default: nxt_st.state = lpt_pkg::ST_OFF;
      endcase
    end

    // Underflow flag: a new miss wins over a clear in the same cycle
    nxt_st.idle  = (nxt_st.state != lpt_pkg::ST_SHIFT);
    // Ready is offered for exactly the cycle before the pixel clock rises
    nxt_st.ready = (nxt_st.state == lpt_pkg::ST_SHIFT) && !nxt_st.cp &&
                   (nxt_st.div == nxt_st.cphalf - 8'h01);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= RST_ST;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign s_axi_awready      = st_ff.awready;
  assign s_axi_wready       = st_ff.wready;
  assign s_axi_bresp        = st_ff.bresp;
  assign s_axi_bvalid       = st_ff.bvalid;
  assign s_axi_arready      = st_ff.arready;
  assign s_axi_rdata        = st_ff.rdata;
  assign s_axi_rresp        = st_ff.rresp;
  assign s_axi_rvalid       = st_ff.rvalid;
  assign pix_ready          = st_ff.ready;
  assign pixel_shift_clock  = st_ff.cp;
  assign pixel_nibble       = st_ff.nibble;
  assign line_latch         = st_ff.load;
  assign frame_start        = st_ff.frame;
  assign ac_polarity_toggle = st_ff.pol;
  assign panel_enable       = st_ff.en;
  assign video_idle_flag    = st_ff.idle;
endmodule
`default_nettype wire

// ### sim/lpt_panel_model.sv
// Behavioural passive panel with a nibble-pairing register on its data input
`timescale 1ns/10ps
`default_nettype none
module lpt_panel_model (
  input  wire logic        pixel_shift_clock,
  input  wire logic [3:0]  pixel_nibble,
  input  wire logic        line_latch,
  input  wire logic        frame_start,
  input  wire logic        ac_polarity_toggle,
  input  wire logic        panel_enable,
  output logic      [15:0] n_smp,
  output logic      [3:0]  last_nib,
  output logic      [15:0] line_nibs,
  output logic      [15:0] frame_rows,
  output logic      [15:0] flips,
  output logic      [7:0]  demux_byte
);
  logic [15:0] col;
  logic [15:0] row;

  initial begin
    {n_smp, last_nib, line_nibs, frame_rows, flips, demux_byte, col, row} = '0;
  end

  // Samples on the falling edge only, so data must already be steady
  always @(negedge pixel_shift_clock) begin
    last_nib = pixel_nibble;
    n_smp = n_smp + 16'h0001;
    col = col + 16'h0001;
    demux_byte = {demux_byte[3:0], pixel_nibble};
  end

  // Delayed so a nibble falling on the same step lands first
  always @(posedge line_latch) begin
    #1;
    line_nibs = col;
    col = 16'h0000;
    row = row + 16'h0001;
  end

  always @(posedge frame_start) begin
    #2;
    frame_rows = row;
    row = 16'h0000;
  end

  always @(negedge panel_enable) begin
    col = 16'h0000;
    row = 16'h0000;
  end

  always @(posedge ac_polarity_toggle or negedge ac_polarity_toggle) begin
    flips = flips + 16'h0001;
  end
endmodule
`default_nettype wire

// ### sim/lpt_top_chk.sv
// Port-level assertions of the LCD timing port
`timescale 1ns/10ps
`default_nettype none
module lpt_top_chk (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       pixel_shift_clock,
  input wire logic [3:0] pixel_nibble,
  input wire logic       line_latch,
  input wire logic       frame_start,
  input wire logic       ac_polarity_toggle,
  input wire logic       panel_enable,
  input wire logic       video_idle_flag
);
  logic [3:0] lines_ff;
  logic [3:0] nxt_lines;

  // Saturating count of latch cycles since the last frame pulse
  always_comb begin
    nxt_lines = lines_ff;
    if (frame_start) nxt_lines = 4'h0;
    else if (line_latch && lines_ff != 4'hF) nxt_lines = lines_ff + 4'h1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) lines_ff <= 4'h0;
    else lines_ff <= nxt_lines;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_off_quiet;
    !panel_enable ##1 !panel_enable |->
      !pixel_shift_clock && !line_latch && !frame_start && pixel_nibble == 4'h0;
  endproperty
  property p_nib_on_rise;
    panel_enable && $changed(pixel_nibble) |-> $rose(pixel_shift_clock);
  endproperty
  property p_nib_hold_fall;
    panel_enable && $fell(pixel_shift_clock) |-> $stable(pixel_nibble);
  endproperty
  property p_clk_busy;
    pixel_shift_clock |-> !video_idle_flag;
  endproperty
  property p_latch_rest;
    line_latch |=> video_idle_flag;
  endproperty
  property p_latch_noclk;
    line_latch |-> !pixel_shift_clock;
  endproperty
  property p_frame_quiet;
    frame_start |-> !pixel_shift_clock && !line_latch;
  endproperty
  property p_frame_lines;
    $rose(frame_start) |-> lines_ff != 4'h0;
  endproperty
  property p_pol_rest;
    $changed(ac_polarity_toggle) |-> video_idle_flag && !pixel_shift_clock;
  endproperty

  a_off_quiet: assert property (p_off_quiet) else $error("panel active while off");
  a_nib_on_rise: assert property (p_nib_on_rise) else $error("data moved off rise");
  a_nib_hold_fall: assert property (p_nib_hold_fall) else $error("data moved at fall");
  a_clk_busy: assert property (p_clk_busy) else $error("idle while clocking");
  a_latch_rest: assert property (p_latch_rest) else $error("no idle after latch");
  a_latch_noclk: assert property (p_latch_noclk) else $error("latch during shift");
  a_frame_quiet: assert property (p_frame_quiet) else $error("frame during line");
  a_frame_lines: assert property (p_frame_lines) else $error("frame without lines");
  a_pol_rest: assert property (p_pol_rest) else $error("polarity moved in burst");

  c_frame: cover property ($rose(frame_start));
  c_pol: cover property ($changed(ac_polarity_toggle));
  c_off: cover property ($fell(panel_enable));
endmodule
`default_nettype wire

// ### sim/test_lcd_panel_timing_port.sv
// Self-checking bench of the LCD timing port
`timescale 1ns/10ps
`default_nettype none
`include "lpt_consts.svh"
module test_lcd_panel_timing_port;
  logic        aclk, aresetn, ce;
  logic [7:0]  awaddr, araddr;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, rdv;
  logic [3:0]  wstrb, pnib, last_nib;
  logic [1:0]  bresp, rresp, resp;
  logic [15:0] pix_word, n_smp, seen, line_nibs, frame_rows, flips;
  logic        pix_valid, pix_ready, pclk, latch, frame, pol, pen, idle;
  logic        chk_data, starve;
  logic        fr_q, pen_q;
  logic [3:0]  nfr;
  logic [1:0]  cur_mode;
  logic [3:0]  expq[$];
  int          mismatches, n_checks;
  logic [7:0]  offs[6] = '{`LPT_OFF_CTRL, `LPT_OFF_HSIZE, `LPT_OFF_VSIZE, `LPT_OFF_ACCNT,
                           `LPT_OFF_CPHALF, `LPT_OFF_HGAP};
  logic [31:0] rstv[6] = '{32'h0000_0000, 32'(`LPT_RST_HSIZE), 32'(`LPT_RST_VSIZE),
                           32'(`LPT_RST_ACCNT), 32'(`LPT_RST_CPHALF), 32'(`LPT_RST_HGAP)};

  lpt_top u_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pix_word(pix_word), .pix_valid(pix_valid), .pix_ready(pix_ready),
    .pixel_shift_clock(pclk), .pixel_nibble(pnib), .line_latch(latch), .frame_start(frame),
    .ac_polarity_toggle(pol), .panel_enable(pen), .video_idle_flag(idle));

  lpt_panel_model u_panel (.pixel_shift_clock(pclk), .pixel_nibble(pnib), .line_latch(latch),
    .frame_start(frame), .ac_polarity_toggle(pol), .panel_enable(pen), .n_smp(n_smp),
    .last_nib(last_nib), .line_nibs(line_nibs), .frame_rows(frame_rows), .flips(flips),
    .demux_byte());

  initial aclk = 1'h0;
  always #10 aclk = ~aclk;

  // Mono takes each level's top bit; gray and colour compare against the frame phase
  function automatic logic [3:0] exp_nib(input logic [15:0] w, input logic [1:0] m,
                                         input logic [3:0] ph);
    logic [3:0] r;
    logic [3:0] lvl;
    logic [3:0] thr;
    r = 4'h0;
    for (int i = 0; i < 4; i++) begin
      lvl = w[4*i +: 4];
      thr = (m == 2'h2) ? 4'(ph + 4'(4 * i)) : ph;
      r[i] = (m == 2'h1 || m == 2'h2) ? (lvl > thr) : lvl[3];
    end
    return r;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic give_verdict;
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic done;
    done = 1'h0;
    awaddr <= a; wdata <= d; wstrb <= 4'hF; awvalid <= 1'h1; wvalid <= 1'h1; bready <= 1'h1;
    while (!done) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid && bready) begin
        resp = bresp;
        done = 1'h1;
      end
    end
    bready <= 1'h0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a);
    logic done;
    done = 1'h0;
    araddr <= a; arvalid <= 1'h1; rready <= 1'h1;
    while (!done) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid && rready) begin
        rdv = rdata;
        resp = rresp;
        done = 1'h1;
      end
    end
    rready <= 1'h0;
    @(posedge aclk);
  endtask

  // Waits for a rising frame pulse; the watchdog ends a hang
  task automatic wait_frame;
    while (frame !== 1'h0) @(posedge aclk);
    while (frame !== 1'h1) @(posedge aclk);
  endtask

  // Every pixel-clock request pushes what the panel should see, zero if starved
  always @(posedge aclk) begin
    pix_valid <= !starve;
    // Dither phase steps when a frame pulse ends while the panel was enabled
    if (fr_q === 1'h1 && frame === 1'h0 && pen_q === 1'h1) nfr = nfr + 4'h1;
    fr_q = frame;
    pen_q = pen;
    if (aresetn && pix_ready === 1'h1) begin
      expq.push_back(pix_valid ? exp_nib(pix_word, cur_mode, nfr) : 4'h0);
      pix_word <= 16'($urandom);
    end
    if (n_smp != seen) begin
      seen = n_smp;
      if (chk_data && expq.size() > 0) chk(32'(last_nib), 32'(expq.pop_front()));
    end
  end

  task automatic run_mode(input int m);
    logic [31:0] h, v, ac, f0;
    h = (m == 3) ? 32'h0000_0000 : 32'(2 + $urandom % 5);
    v = 32'(2 + $urandom % 3);
    ac = 32'(m % 2);
    chk_data = 1'h0;
    wr(`LPT_OFF_CTRL, 32'h0000_0000);
    repeat (4) @(posedge aclk);
    chk(32'({pclk, latch, frame, pen, pnib}), 32'h0000_0000);
    expq.delete();
    seen = n_smp;
    chk_data = 1'h1;
    cur_mode = 2'(m);
    wr(`LPT_OFF_HSIZE, h);
    wr(`LPT_OFF_VSIZE, v);
    wr(`LPT_OFF_ACCNT, 32'h0000_0000);
    wr(`LPT_OFF_CPHALF, (m == 0) ? 32'h0000_0004 : 32'h0000_0001);
    wr(`LPT_OFF_HGAP, 32'($urandom % 3));
    rd(`LPT_OFF_ACCNT);
    chk(rdv, 32'h0000_0001);
    wr(`LPT_OFF_CTRL, {27'h0, ac[0], 1'(m == 2), 2'(m), 1'h1});
    wait_frame();
    chk(32'(pen), 32'h0000_0001);
    f0 = 32'(flips);
    wait_frame();
    chk(32'(line_nibs), (h == 0) ? 32'h0000_0001 : ((m == 2) ? {h[30:0], 1'h0} : h));
    chk(32'(frame_rows), v);
    chk(32'(flips) - f0, (ac != 0) ? v : 32'h0000_0001);
  endtask

  initial begin
    aresetn = 1'h0; ce = 1'h1; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0000_0000;
    wstrb = 4'h0; awvalid = 1'h0; wvalid = 1'h0; bready = 1'h0; arvalid = 1'h0;
    rready = 1'h0; pix_word = 16'h0000; pix_valid = 1'h0; chk_data = 1'h0; starve = 1'h0;
    seen = 16'h0000; mismatches = 0; n_checks = 0;
    nfr = 4'h0;
    fr_q = 1'h0;
    pen_q = 1'h0;
    cur_mode = 2'h0;
    void'($urandom(35030));
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    chk(32'({pen, idle}), 32'h0000_0001);
    for (int i = 0; i < 6; i++) begin
      rd(offs[i]);
      chk(rdv, rstv[i]);
    end
    rd(8'h1C);
    chk({rdv[29:0], resp}, 32'(`LPT_RESP_SLVERR));
    wr(8'h06, 32'h0000_0001);
    chk(32'(resp), 32'(`LPT_RESP_SLVERR));
    for (int m = 0; m < 4; m++) run_mode(m);
    // Starving the source must still clock out zero nibbles and flag it
    starve <= 1'h1;
    repeat (12) @(posedge aclk);
    starve <= 1'h0;
    rd(`LPT_OFF_STATUS);
    chk(32'(rdv[`LPT_STAT_UNDER]), 32'h0000_0001);
    wr(`LPT_OFF_STATUS, 32'h0000_0004);
    rd(`LPT_OFF_STATUS);
    chk(32'(rdv[`LPT_STAT_UNDER]), 32'h0000_0000);
    give_verdict();
  end

  initial begin
    repeat (40000) @(posedge aclk);
    mismatches++;
    give_verdict();
  end
endmodule

bind lpt_top lpt_top_chk u_chk (.aclk(aclk), .aresetn(aresetn),
  .pixel_shift_clock(pixel_shift_clock), .pixel_nibble(pixel_nibble), .line_latch(line_latch),
  .frame_start(frame_start), .ac_polarity_toggle(ac_polarity_toggle),
  .panel_enable(panel_enable), .video_idle_flag(video_idle_flag));
`default_nettype wire
